// File: logic/sfcf_map.vh
`ifndef SFCF_MAP_VH
`define SFCF_MAP_VH
// ----------------------------------------
// serial frame layout, 528-byte page size
// ----------------------------------------
`define SFCF_OPCODE_BITS 8
`define SFCF_ADDR_BITS 24
`define SFCF_RSVD_BITS 2
`define SFCF_PAGE_BITS 12
`define SFCF_BYTE_BITS 10
`define SFCF_PAGE_LSB 10
`define SFCF_BYTE_LSB 0
`define SFCF_FRAME_BITS 32
// ----------------------------------------
// clock and power-up timing
// ----------------------------------------
`define SFCF_CLK_MHZ 125
`define SFCF_SUPPLY_TO_SELECT_WAIT_US 70
`define SFCF_POWER_UP_WRITE_WAIT_MS 20
// ----------------------------------------
// reset values and power state codes
// ----------------------------------------
`define SFCF_MODE_RESET 1'b1
`define SFCF_PWR_STANDBY 2'h0
`define SFCF_PWR_ACTIVE 2'h1
`define SFCF_PWR_DEEP 2'h2
`endif

// File: logic/sfcf_sync.v
`timescale 1ns/1ps
`default_nettype none
// ----------------------------------------
// two-flop synchroniser, one per bit
// ----------------------------------------
module sfcf_sync
#(
	parameter WIDTH = 3,
	parameter [WIDTH-1:0] INIT = {WIDTH{1'b1}}
)
(
	input wire clk,
	input wire rst_n,
	input wire [WIDTH-1:0] async_in,
	output wire [WIDTH-1:0] sync_out
);
	reg [WIDTH-1:0] meta_q;
	reg [WIDTH-1:0] sync_q;
	genvar i;
	// each bit gets its own pair of flops
	generate
		for (i = 0; i < WIDTH; i = i + 1)
		begin : g_bit
			always @(posedge clk or negedge rst_n)
			begin
				if (!rst_n)
				begin
					meta_q[i] <= INIT[i];
					sync_q[i] <= INIT[i];
				end
				else
				begin
					meta_q[i] <= async_in[i];
					sync_q[i] <= meta_q[i];
				end
			end
		end
	endgenerate
	assign sync_out = sync_q;
endmodule // sfcf_sync
`default_nettype wire

// File: logic/sfcf_front.v
`timescale 1ns/1ps
`default_nettype none
`include "sfcf_map.vh"
module sfcf_front
#(
	parameter CLK_MHZ = `SFCF_CLK_MHZ,
	parameter WRITE_WAIT_CYCLES = `SFCF_POWER_UP_WRITE_WAIT_MS * 1000 * CLK_MHZ,
	parameter SELECT_WAIT_CYCLES = `SFCF_SUPPLY_TO_SELECT_WAIT_US * CLK_MHZ
)
(
	input wire clk,
	input wire rst_n,
	input wire cs_n,
	input wire sck,
	input wire si,
	input wire so_data,
	input wire so_data_valid,
	output reg so_out,
	output reg so_oe_n,
	output reg mode3_q,
	output reg [7:0] opcode_q,
	output reg [`SFCF_PAGE_BITS-1:0] page_addr_q,
	output reg [`SFCF_BYTE_BITS-1:0] byte_addr_q,
	output reg addr_valid_q,
	output reg cmd_valid_q,
	output reg write_allowed_q,
	output reg select_wait_done_q,
	output reg [1:0] power_state_q
);
	// ----------------------------------------
	// pin synchronisation
	// ----------------------------------------
	wire [2:0] pins_s;
	wire cs_n_s;
	wire sck_s;
	wire si_s;
	sfcf_sync #(.WIDTH(3), .INIT(3'h7)) u_sync
	(
		.clk(clk),
		.rst_n(rst_n),
		.async_in({cs_n, sck, si}),
		.sync_out(pins_s)
	);
	assign cs_n_s = pins_s[2];
	assign sck_s = pins_s[1];
	assign si_s = pins_s[0];

	// ----------------------------------------
	// edge detection
	// ----------------------------------------
	reg cs_n_d1_q;
	reg sck_d1_q;
	wire cs_fall;
	wire sck_rise;
	wire sck_fall;
	// history flops start at the pins' idle-high level, like the synchroniser
	always @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			cs_n_d1_q <= 1'b1;
			sck_d1_q <= 1'b1;
		end
		else
		begin
			cs_n_d1_q <= cs_n_s;
			sck_d1_q <= sck_s;
		end
	end

	// ----------------------------------------
	// select qualification after reset
	// ----------------------------------------
	// the synchroniser starts idle-high, so a select pin held low through
	// reset would look like a fresh fall once the pipe fills; a frame may
	// only begin after the pin has really been seen high since release
	reg [1:0] settle_q;
	reg cs_idle_seen_q;
	always @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			settle_q <= 2'h0;
			cs_idle_seen_q <= 1'b0;
		end
		else
		begin
			// two edges until the synchronised pin is the real pin
			if (settle_q != 2'h2)
				settle_q <= settle_q + 2'h1;
			else if (cs_n_s)
				cs_idle_seen_q <= 1'b1;
		end
	end
	// a fall counts only once the pin was idle; no cost in normal use
	assign cs_fall = cs_idle_seen_q & cs_n_d1_q & ~cs_n_s;
	assign sck_rise = ~sck_d1_q & sck_s;
	assign sck_fall = sck_d1_q & ~sck_s;

	// ----------------------------------------
	// power-up timers
	// ----------------------------------------
	localparam CW = 32;
	reg [CW-1:0] wr_cnt_q;
	reg [CW-1:0] sel_cnt_q;
	// counts start at reset release; write gate opens at the end
	always @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			wr_cnt_q <= {CW{1'b0}};
			sel_cnt_q <= {CW{1'b0}};
			write_allowed_q <= 1'b0;
			select_wait_done_q <= 1'b0;
		end
		else
		begin
			if (!write_allowed_q)
				wr_cnt_q <= wr_cnt_q + 32'h1;
			if (wr_cnt_q >= WRITE_WAIT_CYCLES[CW-1:0] - 32'h1)
				write_allowed_q <= 1'b1;
			if (!select_wait_done_q)
				sel_cnt_q <= sel_cnt_q + 32'h1;
			// status only: the host owns this wait
			if (sel_cnt_q >= SELECT_WAIT_CYCLES[CW-1:0] - 32'h1)
				select_wait_done_q <= 1'b1;
		end
	end

	// ----------------------------------------
	// frame shifter
	// ----------------------------------------
	reg armed_q;
	reg [5:0] bit_cnt_q;
	reg [`SFCF_FRAME_BITS-1:0] shift_q;
	wire sample_edge;
	wire shift_edge;
	wire [`SFCF_FRAME_BITS-1:0] shift_d;
	// both modes sample on the rising clock edge
	assign sample_edge = sck_rise;
	assign shift_edge = sck_fall;
	assign shift_d = {shift_q[`SFCF_FRAME_BITS-2:0], si_s};

	// frame state; reset itself blocks everything while held
	always @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			armed_q <= 1'b0;
			mode3_q <= `SFCF_MODE_RESET;
			bit_cnt_q <= 6'h0;
			shift_q <= {`SFCF_FRAME_BITS{1'b0}};
			opcode_q <= 8'h0;
			page_addr_q <= {`SFCF_PAGE_BITS{1'b0}};
			byte_addr_q <= {`SFCF_BYTE_BITS{1'b0}};
			addr_valid_q <= 1'b0;
			cmd_valid_q <= 1'b0;
		end
		else
		begin
			cmd_valid_q <= 1'b0;
			if (cs_fall)
			begin
				armed_q <= 1'b1;
				mode3_q <= sck_s;
				bit_cnt_q <= 6'h0;
				addr_valid_q <= 1'b0;
			end
			else if (cs_n_s)
			begin
				armed_q <= 1'b0;
			end
			else if (armed_q && sample_edge && bit_cnt_q < 6'd32)
			begin
				shift_q <= shift_d;
				bit_cnt_q <= bit_cnt_q + 6'h1;
				if (bit_cnt_q == 6'd7)
				begin
					opcode_q <= shift_d[7:0];
					cmd_valid_q <= 1'b1;
				end
				if (bit_cnt_q == 6'd31)
				begin
					// reserved top bits dropped
					page_addr_q <= shift_d[`SFCF_PAGE_LSB+`SFCF_PAGE_BITS-1:`SFCF_PAGE_LSB];
					byte_addr_q <= shift_d[`SFCF_BYTE_LSB+`SFCF_BYTE_BITS-1:`SFCF_BYTE_LSB];
					addr_valid_q <= 1'b1;
				end
			end
		end
	end

	// ----------------------------------------
	// output pin and power state
	// ----------------------------------------
	// drive only for read data within a live frame, change on falling edge
	always @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			so_out <= 1'b0;
			so_oe_n <= 1'b1;
			power_state_q <= `SFCF_PWR_STANDBY;
		end
		else
		begin
			if (cs_n_s || !armed_q || !so_data_valid)
				so_oe_n <= 1'b1;
			else if (shift_edge)
			begin
				so_oe_n <= 1'b0;
				so_out <= so_data;
			end
			power_state_q <= (armed_q && !cs_n_s) ? `SFCF_PWR_ACTIVE : `SFCF_PWR_STANDBY;
		end
	end
endmodule // sfcf_front
`default_nettype wire

// File: testbench/sfcf_front_properties.sv
`timescale 1ns/1ps
`default_nettype none
module sfcf_chk #(parameter WRITE_WAIT_CYCLES = 200)
(
	input wire clk,
	input wire rst_n,
	input wire cs_n,
	input wire so_data_valid,
	input wire so_oe_n,
	input wire mode3_q,
	input wire addr_valid_q,
	input wire cmd_valid_q,
	input wire write_allowed_q,
	input wire [1:0] power_state_q
);
	int cyc_q;
	default clocking @(posedge clk); endclocking
	default disable iff (!rst_n);
	// cycles since release, saturating so it never wraps
	always @(posedge clk or negedge rst_n)
		if (!rst_n)
			cyc_q <= 0;
		else if (cyc_q < 9999)
			cyc_q <= cyc_q + 1;
	chk_mode_reset: assert property ($rose(rst_n) |-> mode3_q) else $error("mode");
	chk_mode_select: assert property ($changed(mode3_q) |-> !cs_n) else $error("mode change");
	chk_cmd_pulse: assert property (cmd_valid_q |=> !cmd_valid_q) else $error("pulse");
	chk_addr_clear: assert property ($fell(cs_n) |-> ##[1:5] !addr_valid_q) else $error("addr");
	chk_oe_idle: assert property (cs_n [*4] |-> so_oe_n) else $error("oe idle");
	chk_oe_cause: assert property (!so_oe_n |-> so_data_valid) else $error("oe cause");
	chk_write_gate: assert property (write_allowed_q |-> cyc_q >= WRITE_WAIT_CYCLES - 1) else $error("wr");
	chk_in_standby: assert property (cs_n [*4] |-> power_state_q == 2'h0) else $error("power");
	chk_active_cmd: assert property (cmd_valid_q |-> power_state_q == 2'h1) else $error("active");
	cover property ($fell(mode3_q));
	cover property (cmd_valid_q);
	cover property ($rose(addr_valid_q));
endmodule // sfcf_chk
bind sfcf_front sfcf_chk #(.WRITE_WAIT_CYCLES(WRITE_WAIT_CYCLES)) u_chk
(
	.clk(clk),
	.rst_n(rst_n),
	.cs_n(cs_n),
	.so_data_valid(so_data_valid),
	.so_oe_n(so_oe_n),
	.mode3_q(mode3_q),
	.addr_valid_q(addr_valid_q),
	.cmd_valid_q(cmd_valid_q),
	.write_allowed_q(write_allowed_q),
	.power_state_q(power_state_q)
);
`default_nettype wire

// File: testbench/sfcf_host.sv
`timescale 1ns/1ps
`default_nettype none
module sfcf_host
(
	output logic cs_n,
	output logic sck,
	output logic si
);
	initial {cs_n, sck, si} = 3'h5;
	// one bit per low-high clock pair, msb first
	task automatic shift(input logic [31:0] v);
		for (int i = 31; i >= 0; i--)
		begin
			sck = 1'b0;
			si = v[i];
			#80 sck = 1'b1;
			#80;
		end
	endtask
	// select pin alone, for frames that break the rules
	task automatic hold(input logic level);
		cs_n = level;
	endtask
	// clock stands still at idle level between frames; it moves only once
	// select has been low long enough for its idle level to be sampled
	task automatic frame(input logic idle, input logic [31:0] v);
		sck = idle;
		#80 cs_n = 1'b0;
		#80;
		shift(v);
		sck = idle;
		si = ~si; // no stale bit once released
		#80 cs_n = 1'b1;
		#80;
	endtask
endmodule // sfcf_host
`default_nettype wire

// File: testbench/serial_flash_cmd_frame_power_up_test.sv
`timescale 1ns/1ps
`default_nettype none
module serial_flash_cmd_frame_power_up_test;
	logic clk = 0, rst_n = 0, so_data = 1, so_data_valid = 0, oe_seen = 0;
	wire cs_n, sck, si, so_out, so_oe_n, mode3_q, addr_valid_q, cmd_valid_q, write_allowed_q, select_wait_done_q;
	wire [7:0] opcode_q;
	wire [11:0] page_addr_q;
	wire [9:0] byte_addr_q;
	wire [1:0] power_state_q;
	int err_count = 0, n_compared = 0, n_cmd = 0;
	sfcf_host host
	(
		.cs_n(cs_n),
		.sck(sck),
		.si(si)
	);
	sfcf_front #(.WRITE_WAIT_CYCLES(200), .SELECT_WAIT_CYCLES(100)) dut
	(
		.clk(clk),
		.rst_n(rst_n),
		.cs_n(cs_n),
		.sck(sck),
		.si(si),
		.so_data(so_data),
		.so_data_valid(so_data_valid),
		.so_out(so_out),
		.so_oe_n(so_oe_n),
		.mode3_q(mode3_q),
		.opcode_q(opcode_q),
		.page_addr_q(page_addr_q),
		.byte_addr_q(byte_addr_q),
		.addr_valid_q(addr_valid_q),
		.cmd_valid_q(cmd_valid_q),
		.write_allowed_q(write_allowed_q),
		.select_wait_done_q(select_wait_done_q),
		.power_state_q(power_state_q)
	);
	// ----
	// clock and output watch
	// ----
	initial forever #4 clk = ~clk;
	always @(posedge clk)
	begin
		n_cmd <= n_cmd + (cmd_valid_q === 1'b1);
		if (so_oe_n === 1'b0) oe_seen <= so_out;
	end
	task step(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask
	task chk(input logic [31:0] got, input logic [31:0] exp);
		n_compared++;
		if (got !== exp)
		begin
			err_count++;
			$display("MISMATCH %0t got %h exp %h", $time, got, exp);
		end
	endtask
	task final_report;
		if (err_count == 0 && n_compared > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask
	// mode 0 frame inside reset must leave no trace
	task t_por;
		rst_n = 0;
		host.frame(0, 32'h85ffffff);
		step(1);
		rst_n = 1;
		step(2);
		chk(mode3_q, 1);
		chk(so_oe_n, 1);
		chk(n_cmd, 0);
		chk(opcode_q, 0);
		chk(power_state_q, 0);
		step(97);
		chk(select_wait_done_q, 0);
		step(1);
		chk(select_wait_done_q, 1);
		step(99);
		chk(write_allowed_q, 0);
		step(1);
		chk(write_allowed_q, 1);
	endtask
	// select held low through reset release is no fall: bits are ignored
	task t_held;
		int c;
		c = n_cmd;
		rst_n = 0;
		host.hold(1'b0);
		step(2);
		rst_n = 1;
		step(4);
		host.shift(32'h0b123456);
		step(4);
		chk(n_cmd, c);
		chk(opcode_q, 0);
		chk(mode3_q, 1);
		chk(addr_valid_q, 0);
		chk(power_state_q, 0);
		host.hold(1'b1);
		step(4);
	endtask
	// fields land msb first in their places
	task t_frame(input logic idle, input logic [31:0] v);
		int c;
		c = n_cmd;
		host.frame(idle, v);
		step(4);
		chk(mode3_q, idle);
		chk(opcode_q, v[31:24]);
		chk(page_addr_q, v[21:10]);
		chk(byte_addr_q, v[9:0]);
		chk(addr_valid_q, 1);
		chk(n_cmd, c + 1);
	endtask
	initial
	begin
		step(3);
		rst_n = 1;
		step(2);
		t_por;
		t_frame(0, 32'h03c00155);
		t_frame(1, 32'h85aaa3ff);
		so_data_valid = 1;
		t_frame(1, 32'he8000000);
		chk(oe_seen, 1);
		chk(so_oe_n, 1);
		t_held;
		t_frame(0, 32'h0b3ffc00);
		final_report;
	end
	// run needs about 35 us; three times that means a hang
	initial
	begin
		#100000;
		err_count++;
		final_report;
	end
endmodule // serial_flash_cmd_frame_power_up_test
`default_nettype wire
